/* src/bsca_speed_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bsca_defines.svh"

module bsca_speed_ctrl
  import bsca_pkg::*;
#(
  parameter int ADC_W = 10,
  parameter int ADC_ZERO_SCALE = 64,
  parameter int ADC_FULL_SCALE = 960,
  parameter int PWM_WIN_LOG2 = 15,
  parameter int PWM_IDLE_STOP_CYC = `BSCA_PWM_IDLE_STOP_CYC,
  parameter int FB_W = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic input_source_select,
  input wire logic serial_command_select,
  input wire logic output_rate_double,
  input wire logic [1:0] loop_feedback_coefficient,
  input wire logic lead_mode_select,
  input wire logic [6:0] lead_time_code,
  input wire logic speed_pin,
  input wire logic [ADC_W-1:0] speed_level,
  input wire logic signed [FB_W-1:0] current_sample,
  input wire logic [`BSCA_AMP_W-1:0] phase_amplitude,
  input wire logic [`BSCA_AMP_W-1:0] bemf_amplitude,
  output logic [`BSCA_CMD_W-1:0] speed_command,
  output logic motor_stop,
  output logic phase_pwm,
  output logic signed [FB_W-1:0] current_filtered,
  output logic [`BSCA_LEAD_CYC_W-1:0] lead_cycles,
  output logic lead_valid
);
  localparam int PROD_W = ADC_W + `BSCA_CMD_W;
  localparam int IDLE_W = $clog2(PWM_IDLE_STOP_CYC + 1);
  localparam int PER_W = 11;
  localparam int DUTY_W = PER_W + `BSCA_CMD_W;
  localparam logic [ADC_W-1:0] ZS = ADC_W'(ADC_ZERO_SCALE);
  localparam logic [ADC_W-1:0] FS = ADC_W'(ADC_FULL_SCALE);
  localparam logic [PROD_W-1:0] SPAN = PROD_W'(ADC_FULL_SCALE - ADC_ZERO_SCALE);
  localparam logic [PER_W-1:0] PER_BASE = PER_W'(`BSCA_PWM_PER_BASE_CYC);
  localparam logic [PER_W-1:0] PER_DOUBLE = PER_W'(`BSCA_PWM_PER_DOUBLE_CYC);
  localparam logic [IDLE_W-1:0] IDLE_LIM = IDLE_W'(PWM_IDLE_STOP_CYC);

  generate
    if (ADC_FULL_SCALE <= ADC_ZERO_SCALE || ADC_FULL_SCALE >= (1 << ADC_W))
      $error("analog thresholds must satisfy zero < full < 2**ADC_W");
    if (PWM_WIN_LOG2 < `BSCA_CMD_W || PWM_WIN_LOG2 > 24)
      $error("PWM_WIN_LOG2 must be in 9..24");
    if (PWM_IDLE_STOP_CYC < 1)
      $error("PWM_IDLE_STOP_CYC must be at least 1");
    if (FB_W < 4)
      $error("FB_W must be at least 4");
    if (ADC_W < 2 || ADC_W > 16)
      $error("ADC_W must be in 2..16");
    if (`BSCA_PWM_PER_BASE_CYC >= (1 << PER_W))
      $error("phase PWM period does not fit its counter");
  endgenerate

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  function automatic bsca_source_t pick_source(input logic serial_sel, input logic pwm_sel);
    if (serial_sel)
      pick_source = BSCA_SRC_SERIAL;
    else if (pwm_sel)
      pick_source = BSCA_SRC_PWM;
    else
      pick_source = BSCA_SRC_ANALOG;
  endfunction : pick_source

  // serial registers
  logic [7:0] low_reg, low_next;
  logic high_stage_reg, high_stage_next;
  logic [`BSCA_CMD_W-1:0] serial_cmd_reg, serial_cmd_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wr_high, wr_low;

  // decoded once, shared by staging and load
  assign wr_high = reg_wr && addr_hit(reg_addr, `BSCA_OFS_SPEED_HIGH);
  assign wr_low = reg_wr && addr_hit(reg_addr, `BSCA_OFS_SPEED_LOW);

  always_comb begin
    low_next = low_reg;
    high_stage_next = high_stage_reg;
    serial_cmd_next = serial_cmd_reg;
    // staged bit survives a low write, so a lone low write reuses it
    if (wr_high)
      high_stage_next = reg_wdata[`BSCA_HIGH_CMD_BIT];
    if (wr_low) begin
      low_next = reg_wdata;
      serial_cmd_next = {high_stage_reg, reg_wdata};
    end
    if (addr_hit(reg_addr, `BSCA_OFS_SPEED_LOW))
      rdata_next = low_reg;
    else if (addr_hit(reg_addr, `BSCA_OFS_SPEED_HIGH))
      rdata_next = {7'h00, high_stage_reg};
    else
      rdata_next = 8'h00;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_reg <= `BSCA_RST_SPEED_LOW;
      high_stage_reg <= 1'b0;
      serial_cmd_reg <= '0;
      rdata_reg <= 8'h00;
    end else begin
      low_reg <= low_next;
      high_stage_reg <= high_stage_next;
      serial_cmd_reg <= serial_cmd_next;
      rdata_reg <= rdata_next;
    end
  end

  // analog path
  logic [`BSCA_CMD_W-1:0] analog_cmd_reg, analog_cmd_next;
  logic [PROD_W-1:0] analog_prod;

  always_comb begin
    analog_prod = PROD_W'(speed_level - ZS) * PROD_W'(`BSCA_CMD_MAX);
    if (speed_level > FS)
      analog_cmd_next = `BSCA_CMD_MAX;
    // truncation lands full scale exactly on the top code
    else if (speed_level >= ZS)
      analog_cmd_next = `BSCA_CMD_W'(analog_prod / SPAN);
    else
      analog_cmd_next = '0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analog_cmd_reg <= '0;
    end else begin
      analog_cmd_reg <= analog_cmd_next;
    end
  end

  // pwm input path: duty measured over a fixed window, slow but glitch tolerant
  logic [PWM_WIN_LOG2-1:0] win_reg, win_next;
  logic [PWM_WIN_LOG2:0] high_reg, high_next;
  logic [`BSCA_CMD_W-1:0] pwm_cmd_reg, pwm_cmd_next;
  logic [IDLE_W-1:0] idle_reg, idle_next;
  logic [PWM_WIN_LOG2:0] high_total;
  logic [PWM_WIN_LOG2:0] duty_scaled;

  always_comb begin
    win_next = win_reg + 1'b1;
    high_total = high_reg + {{PWM_WIN_LOG2{1'b0}}, speed_pin};
    duty_scaled = high_total >> (PWM_WIN_LOG2 - `BSCA_CMD_W);
    high_next = high_total;
    pwm_cmd_next = pwm_cmd_reg;
    if (win_reg == '1) begin
      high_next = '0;
      // fully on lands one past the top code
      if (duty_scaled > (PWM_WIN_LOG2 + 1)'(`BSCA_CMD_MAX))
        pwm_cmd_next = `BSCA_CMD_MAX;
      else
        pwm_cmd_next = `BSCA_CMD_W'(duty_scaled);
    end
    // count saturates so a long stop never wraps back into a run
    if (speed_pin)
      idle_next = '0;
    else if (idle_reg != IDLE_LIM)
      idle_next = idle_reg + 1'b1;
    else
      idle_next = idle_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win_reg <= '0;
      high_reg <= '0;
      pwm_cmd_reg <= '0;
      idle_reg <= '0;
    end else begin
      win_reg <= win_next;
      high_reg <= high_next;
      pwm_cmd_reg <= pwm_cmd_next;
      idle_reg <= idle_next;
    end
  end

  // source selection
  bsca_source_t src;
  logic pwm_idle;
  logic [`BSCA_CMD_W-1:0] cmd_reg, cmd_next;
  logic stop_reg, stop_next;

  always_comb begin
    pwm_idle = (idle_reg == IDLE_LIM);
    // serial select outranks the pin mode bit
    src = pick_source(serial_command_select, input_source_select);
    case (src)
      BSCA_SRC_SERIAL: cmd_next = serial_cmd_reg;
      BSCA_SRC_PWM: cmd_next = pwm_idle ? '0 : pwm_cmd_reg;
      BSCA_SRC_ANALOG: cmd_next = analog_cmd_reg;
      default: cmd_next = '0;
    endcase
    stop_next = (cmd_next == '0);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= '0;
      stop_reg <= 1'b1;
    end else begin
      cmd_reg <= cmd_next;
      stop_reg <= stop_next;
    end
  end

  // phase pwm: duty = command / max of the period
  logic [PER_W-1:0] pcnt_reg, pcnt_next;
  logic [PER_W-1:0] period;
  logic pwm_out_reg, pwm_out_next;
  logic [DUTY_W-1:0] on_lhs, on_rhs;

  always_comb begin
    period = output_rate_double ? PER_DOUBLE : PER_BASE;
    pcnt_next = (pcnt_reg >= period - 1'b1) ? '0 : pcnt_reg + 1'b1;
    // cross-multiplied compare needs no divider per period
    on_lhs = DUTY_W'(pcnt_reg) * DUTY_W'(`BSCA_CMD_MAX);
    on_rhs = DUTY_W'(cmd_reg) * DUTY_W'(period);
    pwm_out_next = on_lhs < on_rhs;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pcnt_reg <= '0;
      pwm_out_reg <= 1'b0;
    end else begin
      pcnt_reg <= pcnt_next;
      pwm_out_reg <= pwm_out_next;
    end
  end

  // feedback attenuation: first-order smoothing, shift grows with coefficient
  logic signed [FB_W-1:0] fb_reg, fb_next;
  logic signed [FB_W:0] fb_diff;

  always_comb begin
    // coefficient 0 passes each sample straight through
    fb_diff = {current_sample[FB_W-1], current_sample} - {fb_reg[FB_W-1], fb_reg};
    fb_next = fb_reg + FB_W'(fb_diff >>> loop_feedback_coefficient);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fb_reg <= '0;
    end else begin
      fb_reg <= fb_next;
    end
  end

  // lead time
  // the divider's latency stays hidden behind the interface
  bsca_lead_if lead_bus ();

  assign lead_bus.code = lead_time_code;
  assign lead_bus.mode = lead_mode_select;
  assign lead_bus.amp_phase = phase_amplitude;
  assign lead_bus.amp_bemf = bemf_amplitude;

  bsca_lead_calc u_lead (
    .clk(clk),
    .resetn(resetn),
    .lead(lead_bus.calc)
  );

  assign reg_rdata = rdata_reg;
  assign speed_command = cmd_reg;
  assign motor_stop = stop_reg;
  assign phase_pwm = pwm_out_reg;
  assign current_filtered = fb_reg;
  assign lead_cycles = lead_bus.lead_cycles;
  assign lead_valid = lead_bus.lead_valid;
endmodule : bsca_speed_ctrl

`default_nettype wire

/* common/bsca_defines.svh */
`ifndef BSCA_DEFINES_SVH
`define BSCA_DEFINES_SVH

// register map of the serial command pair
`define BSCA_OFS_SPEED_LOW 8'h00
`define BSCA_OFS_SPEED_HIGH 8'h01
`define BSCA_RST_SPEED_LOW 8'h00
`define BSCA_RST_SPEED_HIGH 8'h00
`define BSCA_HIGH_CMD_BIT 0

// command scale shared by all three sources
`define BSCA_CMD_W 9
`define BSCA_CMD_MAX 9'h1FF

// clock and timing
`define BSCA_CLK_HZ 50000000
`define BSCA_PWM_OUT_BASE_HZ 25000
`define BSCA_PWM_OUT_DOUBLE_HZ 50000
`define BSCA_PWM_PER_BASE_CYC (`BSCA_CLK_HZ / `BSCA_PWM_OUT_BASE_HZ)
`define BSCA_PWM_PER_DOUBLE_CYC (`BSCA_CLK_HZ / `BSCA_PWM_OUT_DOUBLE_HZ)
`define BSCA_LEAD_STEP_PS 2500000
`define BSCA_LEAD_STEP_CYC ((`BSCA_LEAD_STEP_PS / 1000) * (`BSCA_CLK_HZ / 1000000) / 1000)
`define BSCA_PWM_IDLE_STOP_US 1000
`define BSCA_PWM_IDLE_STOP_CYC (`BSCA_PWM_IDLE_STOP_US * (`BSCA_CLK_HZ / 1000000))

// lead time code fields
`define BSCA_LEAD_MANT_LSB 0
`define BSCA_LEAD_MANT_W 4
`define BSCA_LEAD_EXP_LSB 4
`define BSCA_LEAD_EXP_W 3
`define BSCA_LEAD_CYC_W 18
`define BSCA_AMP_W 10

`endif

/* common/bsca_pkg.sv */
package bsca_pkg;

  // gray sequence idle -> run -> done
  typedef enum logic [1:0] {
    BSCA_DIV_IDLE = 2'b00,
    BSCA_DIV_RUN = 2'b01,
    BSCA_DIV_DONE = 2'b11
  } bsca_div_state_t;

  typedef enum logic [1:0] {
    BSCA_SRC_ANALOG = 2'b00,
    BSCA_SRC_PWM = 2'b01,
    BSCA_SRC_SERIAL = 2'b10
  } bsca_source_t;

endpackage : bsca_pkg

/* common/bsca_lead_if.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bsca_defines.svh"

interface bsca_lead_if;
  logic [6:0] code;
  logic mode;
  logic [`BSCA_AMP_W-1:0] amp_phase;
  logic [`BSCA_AMP_W-1:0] amp_bemf;
  logic [`BSCA_LEAD_CYC_W-1:0] lead_cycles;
  logic lead_valid;

  modport user (output code, output mode, output amp_phase, output amp_bemf,
    input lead_cycles, input lead_valid);
  modport calc (input code, input mode, input amp_phase, input amp_bemf,
    output lead_cycles, output lead_valid);
endinterface : bsca_lead_if

`default_nettype wire

/* src/bsca_lead_calc.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bsca_defines.svh"

module bsca_lead_calc
  import bsca_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  bsca_lead_if.calc lead
);
  localparam int NUM_W = `BSCA_LEAD_CYC_W + `BSCA_AMP_W;
  localparam logic [`BSCA_LEAD_CYC_W-1:0] STEP = `BSCA_LEAD_CYC_W'(`BSCA_LEAD_STEP_CYC);

  logic [`BSCA_LEAD_CYC_W-1:0] base;
  logic [`BSCA_AMP_W-1:0] margin;
  bsca_div_state_t st_reg, st_next;
  logic [NUM_W-1:0] num_reg, num_next;
  logic [`BSCA_AMP_W:0] rem_reg, rem_next;
  logic [`BSCA_AMP_W-1:0] den_reg, den_next;
  logic [4:0] bit_reg, bit_next;
  logic [`BSCA_LEAD_CYC_W-1:0] out_reg, out_next;
  logic valid_reg, valid_next;
  logic [`BSCA_AMP_W:0] trial;

  // step times mantissa, shifted by exponent
  always_comb begin
    base = (STEP * `BSCA_LEAD_CYC_W'(lead.code[`BSCA_LEAD_MANT_LSB +: `BSCA_LEAD_MANT_W]))
      << lead.code[`BSCA_LEAD_EXP_LSB +: `BSCA_LEAD_EXP_W];
    margin = (lead.amp_bemf >= lead.amp_phase) ? '0 : lead.amp_phase - lead.amp_bemf;
  end

  always_comb begin
    st_next = st_reg;
    num_next = num_reg;
    rem_next = rem_reg;
    den_next = den_reg;
    bit_next = bit_reg;
    out_next = out_reg;
    valid_next = valid_reg;
    trial = {rem_reg[`BSCA_AMP_W-1:0], num_reg[NUM_W-1]};
    if (!lead.mode) begin
      out_next = base;
      valid_next = 1'b1;
      st_next = BSCA_DIV_IDLE;
    end else begin
      case (st_reg)
        BSCA_DIV_IDLE: begin
          num_next = NUM_W'(base) * NUM_W'(margin);
          den_next = lead.amp_phase;
          rem_next = '0;
          bit_next = 5'(NUM_W);
          st_next = BSCA_DIV_RUN;
        end
        BSCA_DIV_RUN: begin
          // restoring divide, one quotient bit per clock
          if (trial >= {1'b0, den_reg}) begin
            rem_next = trial - {1'b0, den_reg};
            num_next = {num_reg[NUM_W-2:0], 1'b1};
          end else begin
            rem_next = trial;
            num_next = {num_reg[NUM_W-2:0], 1'b0};
          end
          bit_next = bit_reg - 5'h01;
          if (bit_reg == 5'h01) st_next = BSCA_DIV_DONE;
        end
        BSCA_DIV_DONE: begin
          // zero amplitude gives no lead rather than a divide fault
          out_next = (den_reg == '0) ? '0 : num_reg[`BSCA_LEAD_CYC_W-1:0];
          valid_next = 1'b1;
          st_next = BSCA_DIV_IDLE;
        end
        default: st_next = BSCA_DIV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= BSCA_DIV_IDLE;
      num_reg <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      bit_reg <= '0;
      out_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      num_reg <= num_next;
      rem_reg <= rem_next;
      den_reg <= den_next;
      bit_reg <= bit_next;
      out_reg <= out_next;
      valid_reg <= valid_next;
    end
  end

  assign lead.lead_cycles = out_reg;
  assign lead.lead_valid = valid_reg;
endmodule : bsca_lead_calc

`default_nettype wire

/* sim/bsca_host_pwm.sv */
`timescale 1ns/1ns
`default_nettype none

module bsca_host_pwm (
  input wire logic clk,
  input wire logic run,
  input wire logic [11:0] high_cyc,
  input wire logic [11:0] period,
  output var logic speed_pin
);
  logic [11:0] cnt_reg = 12'h000;

  initial speed_pin = 1'b0;

  // host changes its pin off the sampling edge
  always @(negedge clk) begin
    cnt_reg <= (cnt_reg + 12'h001 >= period) ? 12'h000 : cnt_reg + 12'h001;
    speed_pin <= run && (cnt_reg < high_cyc);
  end
endmodule : bsca_host_pwm

`default_nettype wire

/* sim/bsca_speed_ctrl_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bsca_defines.svh"

module bsca_speed_ctrl_props #(
  parameter int ADC_W = 10,
  parameter int ADC_ZERO_SCALE = 64,
  parameter int ADC_FULL_SCALE = 960
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic input_source_select,
  input wire logic serial_command_select,
  input wire logic lead_mode_select,
  input wire logic [6:0] lead_time_code,
  input wire logic [ADC_W-1:0] speed_level,
  input wire logic [`BSCA_CMD_W-1:0] speed_command,
  input wire logic motor_stop,
  input wire logic phase_pwm,
  input wire logic [`BSCA_LEAD_CYC_W-1:0] lead_cycles
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  stop_tracks_a: assert property (motor_stop == (speed_command == 9'h000))
    else $error("stop flag disagrees with command");
  analog_full_a: assert property ((!serial_command_select && !input_source_select
    && speed_level > ADC_FULL_SCALE)[*3] |-> speed_command == 9'h1FF)
    else $error("analog full scale not maximum");
  analog_stop_a: assert property ((!serial_command_select && !input_source_select
    && speed_level < ADC_ZERO_SCALE)[*3] |-> motor_stop)
    else $error("analog below zero scale not stopped");
  low_load_a: assert property ((reg_wr && reg_addr == 8'h00 && serial_command_select)
    ##1 (serial_command_select && !(reg_wr && reg_addr == 8'h00))
    |=> speed_command[7:0] == $past(reg_wdata, 2))
    else $error("low byte write not loaded");
  serial_hold_a: assert property ((serial_command_select && !reg_wr)[*4]
    |-> $stable(speed_command))
    else $error("serial command moved without a write");
  pwm_full_a: assert property ((speed_command == 9'h1FF)[*3] |-> phase_pwm)
    else $error("maximum command not fully on");
  pwm_zero_a: assert property ((speed_command == 9'h000)[*3] |-> !phase_pwm)
    else $error("zero command drives phase");
  lead_fixed_a: assert property ((!lead_mode_select && $stable(lead_time_code))[*3]
    |-> lead_cycles == (18'(lead_time_code[3:0]) * 18'h0007D) << lead_time_code[6:4])
    else $error("fixed lead time wrong");
  unmapped_zero_a: assert property (reg_addr > 8'h01 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : bsca_speed_ctrl_props

bind bsca_speed_ctrl bsca_speed_ctrl_props #(.ADC_W(ADC_W), .ADC_ZERO_SCALE(ADC_ZERO_SCALE),
  .ADC_FULL_SCALE(ADC_FULL_SCALE)) u_props (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .input_source_select(input_source_select), .serial_command_select(serial_command_select),
  .lead_mode_select(lead_mode_select), .lead_time_code(lead_time_code),
  .speed_level(speed_level), .speed_command(speed_command), .motor_stop(motor_stop),
  .phase_pwm(phase_pwm), .lead_cycles(lead_cycles));

`default_nettype wire

/* sim/bsca_speed_ctrl_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bsca_defines.svh"

module bsca_speed_ctrl_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic src = 1'b0;
  logic ser = 1'b0;
  logic dbl = 1'b0;
  logic [1:0] coef = 2'h0;
  logic lmode = 1'b0;
  logic [6:0] lcode = 7'h00;
  logic [9:0] level = 10'h200;
  logic signed [11:0] isamp = 12'h000;
  logic [9:0] amp_u = 10'h190;
  logic [9:0] amp_b = 10'h000;
  logic run = 1'b0;
  logic [11:0] hi_cyc = 12'h000;
  logic speed_pin;
  logic [7:0] reg_rdata;
  logic [8:0] speed_command;
  logic motor_stop;
  logic phase_pwm;
  logic lead_valid;
  logic signed [11:0] current_filtered;
  logic [17:0] lead_cycles;
  int n_fail = 0;
  int num_checks = 0;

  initial forever #10 clk = ~clk;

  // short window and idle time keep the run brief
  bsca_speed_ctrl #(.PWM_WIN_LOG2(10), .PWM_IDLE_STOP_CYC(200)) DUT (.clk(clk),
    .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .input_source_select(src), .serial_command_select(ser),
    .output_rate_double(dbl), .loop_feedback_coefficient(coef), .lead_mode_select(lmode),
    .lead_time_code(lcode), .speed_pin(speed_pin), .speed_level(level),
    .current_sample(isamp), .phase_amplitude(amp_u), .bemf_amplitude(amp_b),
    .speed_command(speed_command), .motor_stop(motor_stop), .phase_pwm(phase_pwm),
    .current_filtered(current_filtered), .lead_cycles(lead_cycles),
    .lead_valid(lead_valid));

  bsca_host_pwm host (.clk(clk), .run(run), .high_cyc(hi_cyc), .period(12'h040),
    .speed_pin(speed_pin));

  task check(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task wait_cmd(input logic [8:0] exp);
    for (int i = 0; i < 4000 && speed_command !== exp; i++) @(negedge clk);
    check(speed_command, exp);
  endtask : wait_cmd

  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr

  task t_analog;
    logic [9:0] lv [5] = '{10'h3E8, 10'h3C0, 10'h200, 10'h040, 10'h01E};
    logic [8:0] ex [5] = '{9'h1FF, 9'h1FF, 9'h0FF, 9'h000, 9'h000};
    for (int i = 0; i < 5; i++) begin
      level = lv[i];
      repeat (4) @(negedge clk);
      check(speed_command, ex[i]);
      check(motor_stop, ex[i] == 9'h000);
    end
    level = 10'h200;
  endtask : t_analog

  task t_rate;
    int n;
    for (int r = 0; r < 2; r++) begin
      dbl = r[0];
      repeat (2100) @(negedge clk);
      for (n = 0; n < 4100 && phase_pwm !== 1'b0; n++) @(negedge clk);
      for (n = 0; n < 4100 && phase_pwm !== 1'b1; n++) @(negedge clk);
      for (n = 0; n < 4100 && phase_pwm !== 1'b0; n++) @(negedge clk);
      for (; n < 4100 && phase_pwm !== 1'b1; n++) @(negedge clk);
      check(18'(n), 18'(r ? `BSCA_PWM_PER_DOUBLE_CYC : `BSCA_PWM_PER_BASE_CYC));
    end
  endtask : t_rate

  task t_serial;
    ser = 1'b1;
    run = 1'b1;
    hi_cyc = 12'h010;
    wr(8'h01, 8'h01);
    wr(8'h00, 8'hFF);
    @(negedge clk);
    check(speed_command, 9'h1FF);
    check(reg_rdata, 8'hFF);
    reg_addr = 8'h01;
    @(negedge clk);
    check(reg_rdata, 8'h01);
    wr(8'h01, 8'h00);
    repeat (4) @(negedge clk);
    check(speed_command, 9'h1FF);
    wr(8'h00, 8'h5A);
    @(negedge clk);
    check(speed_command, 9'h05A);
    reg_addr = 8'h07;
    @(negedge clk);
    check(reg_rdata, 8'h00);
    ser = 1'b0;
  endtask : t_serial

  task t_pwm;
    src = 1'b1;
    hi_cyc = 12'h040;
    wait_cmd(9'h1FF);
    hi_cyc = 12'h020;
    wait_cmd(9'h100);
    run = 1'b0;
    repeat (150) @(negedge clk);
    check(motor_stop, 1'b0);
    for (int i = 0; i < 80 && motor_stop !== 1'b1; i++) @(negedge clk);
    check(motor_stop, 1'b1);
    check(speed_command, 9'h000);
    src = 1'b0;
  endtask : t_pwm

  task t_filter;
    for (int k = 0; k < 4; k++) begin
      coef = k[1:0];
      isamp = 12'h000;
      repeat (60) @(negedge clk);
      isamp = 12'h400;
      @(negedge clk);
      check({6'h00, current_filtered}, 18'h00400 >> k);
    end
    isamp = 12'h000;
  endtask : t_filter

  task t_lead;
    logic [6:0] cd [4] = '{7'h5A, 7'h7F, 7'h28, 7'h28};
    logic md [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [9:0] bu [4] = '{10'h064, 10'h064, 10'h064, 10'h190};
    logic [17:0] ex [4] = '{18'h09C40, 18'h3A980, 18'h00BB8, 18'h00000};
    for (int i = 0; i < 4; i++) begin
      lcode = cd[i];
      lmode = md[i];
      amp_b = bu[i];
      for (int j = 0; j < 100 && lead_cycles !== ex[i]; j++) @(negedge clk);
      check(lead_cycles, ex[i]);
      check(lead_valid, 1'b1);
    end
  endtask : t_lead

  task complete_run;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (20) @(negedge clk);
    check(speed_command, 9'h000);
    check(motor_stop, 1'b1);
    resetn = 1'b1;
    @(negedge clk);
    t_analog();
    t_rate();
    t_serial();
    t_pwm();
    t_filter();
    t_lead();
    complete_run();
  end
endmodule : bsca_speed_ctrl_tb_top

`default_nettype wire
